// File: core/icc_pkg.sv
// Behaviour
// (R1) uncascaded unit uses own 16-bit timer
// (R2) cascade: odd low half, even high half
// (R3) odd wraparound increments even count
// (R4) software sets cascade bit 8 both units
// (R5) capture rising, every edge, 4th, 16th
// (R6) interrupt rate field selects nth capture
// (R7) mode 111: rising edge interrupt in sleep; here wakeIrq comes from the odd unit only
// (R8) 011 every rising, 101 every 16th
// (R9) not-empty flag while FIFO holds data
// (R10) overflow flag shows capture overflow occurred
// (R11) software picks nonzero sync source field
// (R12) clock-select field picks time base
// (R13) bit 7 trigger mode, clear status
// (R14) even unit forced synchronous when cascaded; here only while the even unit's trigger bit 7 is clear
// (R15) cascaded sync holds both in reset
// (R16) software enables even cascade bit first
// (R17) software programs identical selects both units
// (R18) odd unit settings govern cascaded pair
// (R19) low from odd, high from even
// (R20) capture only with time base and source
// (R21) software drains FIFO before configuring
// (R22) four-entry FIFO, full drops, sets overflow
// (R23) mode 000 disables unit
package icc_pkg;
	localparam logic [3:0] ADDR_CON1_ODD = 4'h0;
	localparam logic [3:0] ADDR_CON2_ODD = 4'h1;
	localparam logic [3:0] ADDR_BUF_ODD  = 4'h2;
	localparam logic [3:0] ADDR_CON1_EVN = 4'h3;
	localparam logic [3:0] ADDR_CON2_EVN = 4'h4;
	localparam logic [3:0] ADDR_BUF_EVN  = 4'h5;
	localparam logic [3:0] ADDR_TMR_ODD  = 4'h6;
	localparam logic [3:0] ADDR_TMR_EVN  = 4'h7;
	localparam int SEL_LO      = 10;
	localparam int SEL_HI      = 12;
	localparam int RATE_LO     = 5;
	localparam int RATE_HI     = 6;
	localparam int OVF_BIT     = 4;
	localparam int BNE_BIT     = 3;
	localparam int CASC_BIT    = 8;
	localparam int TRIG_BIT    = 7;
	localparam int TSTAT_BIT   = 6;
	localparam int SRC_HI      = 4;
	localparam logic [15:0] CON1_RESET = 16'h0000;
	localparam logic [15:0] CON2_RESET = 16'h000d;
	localparam logic [2:0] MODE_OFF    = 3'b000;
	localparam logic [2:0] MODE_EDGE   = 3'b001;
	localparam logic [2:0] MODE_FALL   = 3'b010;
	localparam logic [2:0] MODE_RISE   = 3'b011;
	localparam logic [2:0] MODE_RISE4  = 3'b100;
	localparam logic [2:0] MODE_RISE16 = 3'b101;
	localparam logic [2:0] MODE_SLEEP  = 3'b111;
	localparam logic [3:0] PRE4_LAST   = 4'h3;
	localparam logic [3:0] PRE16_LAST  = 4'hf;
endpackage

// File: core/icc_capture.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module icc_capture #(
	parameter int DEPTH = 4
) (
	// clocking
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// capture pins, asynchronous
	input  wire logic        captureInputOdd,
	input  wire logic        captureInputEven,
	// time base enables and sync/trigger sources
	input  wire logic [7:0]  timebaseTick,
	input  wire logic [31:0] syncSource,
	input  wire logic        sleepMode,
	// register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regRdata,
	// events
	output logic             captureIrqOdd,
	output logic             captureIrqEven,
	output logic             wakeIrq
);
	localparam int PW = $clog2(DEPTH);

	// per-unit registers and state, index 0 odd, 1 even
	logic [15:0]   con1_reg  [2];
	logic [15:0]   con2_reg  [2];
	logic [15:0]   timer_reg [2];
	logic [15:0]   fifo_reg  [2][DEPTH];
	logic [PW-1:0] wptr_reg  [2];
	logic [PW-1:0] rptr_reg  [2];
	logic [PW:0]   count_reg [2];
	logic [3:0]    pre_reg   [2];
	logic [1:0]    evcnt_reg [2];
	logic [2:0]    mode      [2];
	logic [1:0]    rate      [2];
	// pin pipeline and decode
	logic [1:0]    sync1;
	logic [1:0]    sync2;
	logic [1:0]    prev_reg;
	logic          cascade;
	logic [1:0]    run;
	logic [1:0]    capEv;
	logic [1:0]    edgeRise;
	logic [1:0]    edgeAny;
	logic [1:0]    srcHit;
	logic [1:0]    tick;
	logic [1:0]    wrap;
	logic [1:0]    unitRead;
	logic [1:0]    capture;
	logic [1:0]    full;
	logic [1:0]    pushOk;
	logic [1:0]    popOk;
	logic [1:0]    notEmpty;

	function automatic logic [15:0] rdFifo(input logic [15:0] v,
		input logic ok);
		rdFifo = ok ? v : 16'h0000;
	endfunction

	// fifo level decode, gates the read-pointer pop only
	function automatic logic hasData(input logic [PW:0] lvl);
		hasData = lvl != '0;
	endfunction

	// per-unit register decode, same for the buffer, control one and control two pairs
	function automatic logic regHit(input logic strobe,
		input logic [3:0] addr, input int unit,
		input logic [3:0] oddAddr, input logic [3:0] evnAddr);
		regHit = strobe && addr == (unit != 0 ? evnAddr : oddAddr);
	endfunction

	// two flops before any logic sees the pins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1    <= 2'b00;
			sync2    <= 2'b00;
			prev_reg <= 2'b00;
		end else if (clkEn) begin
			sync1    <= {captureInputEven, captureInputOdd};
			sync2    <= sync1;
			prev_reg <= sync2;
		end
	end

	assign cascade = con2_reg[0][icc_pkg::CASC_BIT]
		& con2_reg[1][icc_pkg::CASC_BIT];
	assign edgeRise = sync2 & ~prev_reg;
	assign edgeAny  = sync2 ^ prev_reg;
	assign unitRead[0] = regHit(regRead, regAddr, 0,
		icc_pkg::ADDR_BUF_ODD, icc_pkg::ADDR_BUF_EVN);
	assign unitRead[1] = regHit(regRead, regAddr, 1,
		icc_pkg::ADDR_BUF_ODD, icc_pkg::ADDR_BUF_EVN);
	assign notEmpty[0] = hasData(count_reg[0]);
	assign notEmpty[1] = hasData(count_reg[1]);
	assign full[0] = count_reg[0] == (PW+1)'(DEPTH);
	assign full[1] = count_reg[1] == (PW+1)'(DEPTH);
	assign capture = capEv & run;
	assign pushOk  = capture & ~full; // [R22]
	assign popOk   = unitRead & notEmpty;

	always_comb begin
		for (int u = 0; u < 2; u++) begin
			// odd unit governs the pair
			mode[u] = cascade ? con1_reg[0][2:0] : con1_reg[u][2:0]; // [R18]
			rate[u] = cascade
				? con1_reg[0][icc_pkg::RATE_HI:icc_pkg::RATE_LO]
				: con1_reg[u][icc_pkg::RATE_HI:icc_pkg::RATE_LO]; // [R6]
			srcHit[u] = con2_reg[u][icc_pkg::SRC_HI:0] == 5'h00 ? 1'b1
				: syncSource[con2_reg[u][icc_pkg::SRC_HI:0]];
			tick[u] = timebaseTick[con1_reg[u][icc_pkg::SEL_HI:icc_pkg::SEL_LO]]; // [R12]
		end
		// even unit follows odd when cascaded and not in trigger mode
		if (cascade && !con2_reg[1][icc_pkg::TRIG_BIT]) begin // [R14]
			srcHit[1] = srcHit[0];
			tick[1]   = tick[0];
		end
		for (int u = 0; u < 2; u++) begin
			run[u] = tick[u] && (con2_reg[u][icc_pkg::TRIG_BIT]
				? con2_reg[u][icc_pkg::TSTAT_BIT] : srcHit[u]); // [R20]
		end
		for (int u = 0; u < 2; u++) begin
			unique case (mode[cascade ? 0 : u])
				icc_pkg::MODE_EDGE:   capEv[u] = edgeAny[u]; // [R5]
				icc_pkg::MODE_FALL:   capEv[u] = sync2[u] == 1'b0 && prev_reg[u];
				icc_pkg::MODE_RISE:   capEv[u] = edgeRise[u]; // [R8]
				icc_pkg::MODE_RISE4:  capEv[u] = edgeRise[u]
					&& pre_reg[u] == icc_pkg::PRE4_LAST; // [R5]
				icc_pkg::MODE_RISE16: capEv[u] = edgeRise[u]
					&& pre_reg[u] == icc_pkg::PRE16_LAST; // [R8]
				default:              capEv[u] = 1'b0; // [R23] [R7]
			endcase
		end
		// one capture of the pair, driven by the odd pin
		if (cascade) capEv[1] = capEv[0]; // [R2]
		// a held or stopped low half never carries into the high half
		wrap[0] = run[0] && mode[0] != icc_pkg::MODE_OFF
			&& timer_reg[0] == 16'hffff; // [R3]
		wrap[1] = 1'b0;
	end

	// timers: cascaded sync mode holds both until source comes up
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			timer_reg[0] <= 16'h0000;
			timer_reg[1] <= 16'h0000;
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++) begin
				if (mode[u] == icc_pkg::MODE_OFF || !run[u]) begin
					if (cascade && !con2_reg[0][icc_pkg::TRIG_BIT]
						&& !srcHit[0])
						timer_reg[u] <= 16'h0000; // [R15]
				end else if (cascade && u == 1) begin
					if (wrap[0])
						timer_reg[1] <= timer_reg[1] + 16'h0001; // [R3]
				end else begin
					timer_reg[u] <= timer_reg[u] + 16'h0001; // [R1]
				end
			end
		end
	end

	// prescaler counts rising edges
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pre_reg[0] <= 4'h0;
			pre_reg[1] <= 4'h0;
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++)
				if (mode[u] == icc_pkg::MODE_OFF || !run[u])
					pre_reg[u] <= 4'h0;
				else if (edgeRise[u])
					pre_reg[u] <= (mode[u] == icc_pkg::MODE_RISE4
						&& pre_reg[u] == icc_pkg::PRE4_LAST)
						? 4'h0 : pre_reg[u] + 4'h1;
		end
	end

	// fifo; a capture into a full fifo is dropped, never overwrites
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int u = 0; u < 2; u++) begin
				wptr_reg[u]  <= '0;
				rptr_reg[u]  <= '0;
				count_reg[u] <= '0;
			end
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++) begin
				if (popOk[u])
					rptr_reg[u] <= PW'(rptr_reg[u] + 1'b1);
				if (pushOk[u]) begin
					fifo_reg[u][wptr_reg[u]] <= timer_reg[u]; // [R22]
					wptr_reg[u] <= PW'(wptr_reg[u] + 1'b1);
				end
				count_reg[u] <= count_reg[u] + (PW+1)'(pushOk[u])
					- (PW+1)'(popOk[u]);
			end
		end
	end

	// interrupt divider; restarts whenever the unit is switched off
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			evcnt_reg[0]   <= 2'b00;
			evcnt_reg[1]   <= 2'b00;
			captureIrqOdd  <= 1'b0;
			captureIrqEven <= 1'b0;
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++) begin
				if (mode[u] == icc_pkg::MODE_OFF)
					evcnt_reg[u] <= 2'b00; // [R23]
				else if (capture[u])
					evcnt_reg[u] <= evcnt_reg[u] == rate[u]
						? 2'b00 : evcnt_reg[u] + 2'b01; // [R6]
			end
			captureIrqOdd  <= capture[0] && evcnt_reg[0] == rate[0]; // [R6]
			// the pair reports through the odd unit only
			captureIrqEven <= capture[1] && evcnt_reg[1] == rate[1]
				&& !cascade; // [R18]
		end
	end

	// sleep wake-up ignores every other control bit
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			wakeIrq <= 1'b0;
		else if (clkEn)
			wakeIrq <= sleepMode && mode[0] == icc_pkg::MODE_SLEEP
				&& edgeRise[0]; // [R7]
	end

	// control one; overflow is sticky, set beats a software clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			con1_reg[0] <= icc_pkg::CON1_RESET;
			con1_reg[1] <= icc_pkg::CON1_RESET;
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++) begin
				if (regHit(regWrite, regAddr, u, icc_pkg::ADDR_CON1_ODD,
					icc_pkg::ADDR_CON1_EVN)) begin
					// not-empty is rebuilt on read-back, never stored
					con1_reg[u] <= {regWdata[15:5], con1_reg[u][4],
						1'b0, regWdata[2:0]};
					if (!regWdata[icc_pkg::OVF_BIT])
						con1_reg[u][icc_pkg::OVF_BIT] <= 1'b0;
				end
				if (capture[u] && full[u])
					con1_reg[u][icc_pkg::OVF_BIT] <= 1'b1; // [R10] [R22]
			end
		end
	end

	// control two; trigger status set by hardware, cleared by a write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			con2_reg[0] <= icc_pkg::CON2_RESET;
			con2_reg[1] <= icc_pkg::CON2_RESET;
		end else if (clkEn) begin
			for (int u = 0; u < 2; u++) begin
				if (regHit(regWrite, regAddr, u, icc_pkg::ADDR_CON2_ODD,
					icc_pkg::ADDR_CON2_EVN))
					con2_reg[u] <= regWdata; // [R13]
				else if (con2_reg[u][icc_pkg::TRIG_BIT] && srcHit[u]
					&& con2_reg[u][icc_pkg::SRC_HI:0] != 5'h00)
					con2_reg[u][icc_pkg::TSTAT_BIT] <= 1'b1; // [R13]
			end
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			regRdata <= 16'h0000;
		end else if (clkEn) begin
			regRdata <= 16'h0000;
			if (regRead) begin
				unique case (regAddr)
					icc_pkg::ADDR_CON1_ODD: regRdata <= con1_reg[0]
						| {12'h000, count_reg[0] != '0, 3'b000}; // [R9]
					icc_pkg::ADDR_CON1_EVN: regRdata <= con1_reg[1]
						| {12'h000, count_reg[1] != '0, 3'b000}; // [R9]
					icc_pkg::ADDR_CON2_ODD: regRdata <= con2_reg[0];
					icc_pkg::ADDR_CON2_EVN: regRdata <= con2_reg[1];
					icc_pkg::ADDR_BUF_ODD:  regRdata <= rdFifo(
						fifo_reg[0][rptr_reg[0]], count_reg[0] != '0); // [R19]
					icc_pkg::ADDR_BUF_EVN:  regRdata <= rdFifo(
						fifo_reg[1][rptr_reg[1]], count_reg[1] != '0); // [R19]
					icc_pkg::ADDR_TMR_ODD:  regRdata <= timer_reg[0];
					icc_pkg::ADDR_TMR_EVN:  regRdata <= timer_reg[1];
					default:                regRdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule // icc_capture

// File: bench/icc_monitor.sv
`timescale 1ns/10ps
module icc_monitor (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        captureInputOdd,
	input wire logic        captureInputEven,
	input wire logic        sleepMode,
	input wire logic [3:0]  regAddr,
	input wire logic        regRead,
	input wire logic [15:0] regRdata,
	input wire logic        captureIrqOdd,
	input wire logic        captureIrqEven,
	input wire logic        wakeIrq
);
	logic       pO, pE, rise;
	logic [3:0] aO, aE, aR;
	assign rise = (captureInputOdd & ~pO) | (captureInputEven & ~pE);
	always_ff @(posedge sys_clk) begin
		pO <= captureInputOdd;
		pE <= captureInputEven;
	end
	// ages saturate so a stale edge never looks fresh
	always_ff @(posedge sys_clk) begin
		aO <= (captureInputOdd != pO) ? 4'h0 : aO + {3'h0, aO != 4'hf};
		aE <= (captureInputEven != pE) ? 4'h0 : aE + {3'h0, aE != 4'hf};
		aR <= rise ? 4'h0 : aR + {3'h0, aR != 4'hf};
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_odd_irq_cause: assert property (captureIrqOdd |-> aO <= 4'h6)
		else $error("odd capture pulse with no pin edge");
	a_even_irq_cause: assert property (captureIrqEven |-> aE <= 4'h6)
		else $error("even capture pulse with no pin edge");
	a_wake_rise_only: assert property (wakeIrq |-> aR <= 4'h6)
		else $error("wake pulse with no rising edge");
	a_wake_in_sleep: assert property (wakeIrq |-> $past(sleepMode))
		else $error("wake pulse while awake");
	a_wake_no_capture: assert property (wakeIrq |-> !captureIrqOdd)
		else $error("capture pulse in wake mode");
	a_rdata_read_only: assert property (!$past(regRead) |-> regRdata == 0)
		else $error("read data outside answer cycle");
	a_unmapped_reads_zero: assert property ($past(regRead) &&
		$past(regAddr) > 4'h7 |-> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property ($rose(rst_n) |->
		!captureIrqOdd && !captureIrqEven && !wakeIrq)
		else $error("event pulse right after reset");
endmodule // icc_monitor
bind icc_capture icc_monitor mon_u (.sys_clk, .rst_n, .captureInputOdd,
	.captureInputEven, .sleepMode, .regAddr, .regRead, .regRdata,
	.captureIrqOdd, .captureIrqEven, .wakeIrq);

// File: bench/icc_pin_src.sv
`timescale 1ns/10ps
module icc_pin_src (
	input wire logic sys_clk,
	output logic     pinOdd,
	output logic     pinEven
);
	initial {pinEven, pinOdd} = 2'b00;
	// edges held 4 cycles so each one survives the two-flop sync
	task automatic pulses(input int n, input logic [1:0] sel);
		repeat (n) begin
			@(posedge sys_clk);
			{pinEven, pinOdd} <= sel;
			repeat (4) @(posedge sys_clk);
			{pinEven, pinOdd} <= 2'b00;
			repeat (3) @(posedge sys_clk);
		end
	endtask
endmodule // icc_pin_src

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
	logic        sys_clk, rst_n, sleepMode, regWrite, regRead;
	logic        pinOdd, pinEven, irqOdd, irqEven, wake;
	logic [3:0]  regAddr;
	logic [15:0] regWdata, regRdata, rdv, prev;
	logic [31:0] syncSource;
	logic [15:0] cfg[6] = '{16'h0063, 16'h0043, 16'h0005, 16'h0004, 16'h0001, 0};
	int          ne[6] = '{4, 3, 32, 8, 2, 2};
	int          ni[6] = '{1, 1, 2, 2, 4, 0};
	int          error_cnt = 0, checks_done = 0, nOdd, nEven, nWake;
	icc_pin_src src_u (.sys_clk(sys_clk), .pinOdd(pinOdd), .pinEven(pinEven));
	icc_capture #(.DEPTH(4)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
		.clkEn(1'b1), .captureInputOdd(pinOdd), .captureInputEven(pinEven),
		.timebaseTick(8'h01), .syncSource(syncSource), .sleepMode(sleepMode),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .captureIrqOdd(irqOdd),
		.captureIrqEven(irqEven), .wakeIrq(wake));
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		nOdd += (irqOdd === 1'b1);
		nEven += (irqEven === 1'b1);
		nWake += (wake === 1'b1);
	end
	task chk(input string nm, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{regAddr, regWdata, regWrite} <= {a, d, 1'b1};
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		{regAddr, regRead} <= {a, 1'b1};
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 rdv = regRdata;
	endtask
	task rc(input logic [3:0] a, input logic [15:0] e, input string nm);
		rd(a);
		chk(nm, e, rdv);
	endtask
	task go(input int n, input logic [1:0] sel);
		{nOdd, nEven, nWake} = 0;
		src_u.pulses(n, sel);
		repeat (10) @(posedge sys_clk);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		error_cnt++;
		close_out;
	end
	initial begin
		{rst_n, sleepMode, regWrite, regRead, regAddr, regWdata} = 0;
		syncSource = 0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rc(icc_pkg::ADDR_CON1_ODD, icc_pkg::CON1_RESET, "con1");
		rc(icc_pkg::ADDR_CON2_ODD, icc_pkg::CON2_RESET, "con2");
		rc(4'hf, 16'h0000, "unmapped");
		wr(icc_pkg::ADDR_CON1_ODD, 16'h0c03);
		rd(icc_pkg::ADDR_TMR_ODD);
		prev = rdv;
		rc(icc_pkg::ADDR_TMR_ODD, prev, "unticked timer");
		wr(icc_pkg::ADDR_CON1_ODD, 16'h0003);
		go(2, 2'b01);
		chk("gated irq", 0, nOdd[15:0]);
		wr(icc_pkg::ADDR_CON2_ODD, 16'h0000);
		go(5, 2'b01);
		rc(icc_pkg::ADDR_CON1_ODD, 16'h001b, "full flags");
		prev = 0;
		repeat (4) begin
			rd(icc_pkg::ADDR_BUF_ODD);
			chk("buf order", 1, {15'h0, rdv > prev});
			prev = rdv;
		end
		rc(icc_pkg::ADDR_CON1_ODD, 16'h0013, "drained");
		rc(icc_pkg::ADDR_BUF_ODD, 0, "empty read");
		wr(icc_pkg::ADDR_CON1_ODD, 16'h0003);
		rc(icc_pkg::ADDR_CON1_ODD, 16'h0003, "ovf cleared");
		$display("test fifo done");
		for (int i = 0; i < 6; i++) begin
			wr(icc_pkg::ADDR_CON1_ODD, 0);
			repeat (4) rd(icc_pkg::ADDR_BUF_ODD);
			wr(icc_pkg::ADDR_CON1_ODD, cfg[i]);
			go(ne[i], 2'b01);
			chk("irq count", ni[i], nOdd[15:0]);
		end
		$display("test modes done");
		wr(icc_pkg::ADDR_CON2_EVN, 0);
		wr(icc_pkg::ADDR_CON1_EVN, 16'h0003);
		go(1, 2'b10);
		chk("even alone", 16'h0101, {nEven[7:0], 7'h0, nOdd == 0});
		wr(icc_pkg::ADDR_CON1_EVN, 0);
		rd(icc_pkg::ADDR_BUF_EVN);
		wr(icc_pkg::ADDR_CON2_EVN, 16'h0101);
		wr(icc_pkg::ADDR_CON2_ODD, 16'h0101);
		wr(icc_pkg::ADDR_CON1_ODD, 16'h0003);
		go(2, 2'b01);
		chk("held pair", 0, nOdd[15:0]);
		rc(icc_pkg::ADDR_TMR_ODD, 0, "held timer");
		syncSource <= 32'h2;
		go(2, 2'b01);
		chk("pair irq", 16'h0200, {nOdd[7:0], nEven[7:0]});
		rd(icc_pkg::ADDR_BUF_ODD);
		rc(icc_pkg::ADDR_BUF_EVN, 0, "high word");
		$display("test cascade done");
		wr(icc_pkg::ADDR_CON2_ODD, 0);
		wr(icc_pkg::ADDR_CON1_ODD, 16'h0007);
		sleepMode <= 1'b1;
		go(1, 2'b01);
		chk("sleep wake", 16'h0100, {nWake[7:0], nOdd[7:0]});
		sleepMode <= 1'b0;
		go(1, 2'b01);
		chk("awake wake", 0, nWake[15:0]);
		$display("test wake done");
		close_out;
	end
endmodule // tb
